/* File: bench/bpfs_core_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module bpfs_core_checker
(
	// Core ports
	input wire logic                  clk,
	input wire logic                  nrst,
	input wire bpfs_pkg::bpfs_flags_s flags,
	input wire logic                  rd,
	input wire logic [15:0]           rdata,
	input wire bpfs_pkg::bpfs_drive_s drive
);
	import bpfs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ****************************************
	// Helper counters
	// ****************************************
	int on_cnt;
	int gap_cnt;
	always_ff @(posedge clk)
	begin
		if (!nrst || !drive.high_side_gate)
			on_cnt <= 0;
		else
			on_cnt <= on_cnt + 1;
	end
	always_ff @(posedge clk)
	begin
		if (!nrst)
			gap_cnt <= 0;
		else if ($rose(drive.high_side_gate))
			gap_cnt <= 1;
		else if (gap_cnt != 0)
			gap_cnt <= gap_cnt + 1;
	end
	sequence s_long_on;
		$fell(drive.high_side_gate) && on_cnt >= MAX_ON_PERIODS * PERIOD_CYC;
	endsequence
	property p_excl;
		!(drive.high_side_gate && drive.low_side_gate);
	endproperty
	a_excl: assert property (p_excl) else $error("both gates on");
	property p_fault;
		(flags.thermal || flags.short_circuit || flags.undervoltage_lockout) [*6]
			|-> drive == 4'h3;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not idled");
	property p_pd_pair;
		drive.ss_pulldown == drive.comp_pulldown
			&& !(drive.ss_pulldown && drive.low_side_gate);
	endproperty
	a_pd_pair: assert property (p_pd_pair) else $error("pulldowns split");
	property p_rd_idle;
		!$past(rd) |-> rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_pd_gate;
		drive.ss_pulldown && $past(drive.ss_pulldown) |-> !drive.high_side_gate;
	endproperty
	a_pd_gate: assert property (p_pd_gate) else $error("gate on while idle");
	property p_timeout;
		on_cnt <= MAX_ON_PERIODS * PERIOD_CYC + HALF_PERIOD_CYC + 2;
	endproperty
	a_timeout: assert property (p_timeout) else $error("on time too long");
	property p_refresh;
		s_long_on |-> ##[1:8] drive.low_side_gate;
	endproperty
	a_refresh: assert property (p_refresh) else $error("no refresh");
	property p_period;
		$rose(drive.high_side_gate) && gap_cnt != 0 |-> gap_cnt % PERIOD_CYC == 0;
	endproperty
	a_period: assert property (p_period) else $error("off-period start");
endmodule
bind bpfs_core bpfs_core_checker chk (.clk(clk), .nrst(nrst), .flags(flags), .rd(rd),
	.rdata(rdata), .drive(drive));
`default_nettype wire

/* File: bench/bpfs_fets.sv */
`timescale 1ns/1ns
`default_nettype none
module bpfs_fets
(
	input wire logic                  clk,
	input wire bpfs_pkg::bpfs_drive_s drive,
	output var logic                  switch_node_high
);
	import bpfs_pkg::*;
	// node follows switch
	// Node lags the high-side switch by a cycle, like a real edge
	always_ff @(posedge clk)
		switch_node_high <= drive.high_side_gate;
endmodule
`default_nettype wire

/* File: bench/buck_pwm_fault_sequencer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module buck_pwm_fault_sequencer_test;
	import bpfs_pkg::*;
	localparam int unsigned RCNT = 3;
	logic clk = 1'b0, nrst = 1'b0, uv = 1'b0, th = 1'b0, sc = 1'b0, ss = 1'b0, wr = 1'b0;
	logic rd = 1'b0, sw;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, v;
	bpfs_drive_s drive;
	bpfs_flags_s flags;
	int fails = 0, samples_checked = 0, n;
	int rows [4][2] = '{'{0, 0}, '{1, 1}, '{166, 166}, '{332, 332}};
	assign flags = {uv, th, sc, ss, sw};
	always #5 clk = ~clk;
	bpfs_core #(.RESTART_CNT(RCNT)) dut (.clk(clk), .nrst(nrst), .flags(flags), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .drive(drive));
	bpfs_fets fets (.clk(clk), .drive(drive), .switch_node_high(sw));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Bounded wait: for pulldown release, or for the low side gate
	task automatic wait_on(input bit ls, output int k);
		k = 0;
		while ((ls ? drive.low_side_gate !== 1'b1 : drive.ss_pulldown !== 1'b0) && k < 8000)
		begin
			@(posedge clk);
			#1 k++;
		end
		if (k >= 8000)
		begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic count_hs(output int k);
		k = 0;
		repeat (PERIOD_CYC)
		begin
			@(posedge clk);
			#1 if (drive.high_side_gate === 1'b1) k++;
		end
	endtask
	initial
	begin
		cyc(2);
		nrst <= 1'b1;
		chk({12'h000, drive}, 16'h0003);
		wr_reg(REG_CTRL, 16'h0001);
		wait_on(0, n);
		cyc(10);
		chk(16'(drive.low_side_gate), 16'h0000);
		rd_reg(REG_STATUS, v);
		chk(v, 16'h0040);
		rd_reg(4'hf, v);
		chk(v, 16'h0000);
		ss <= 1'b1;
		cyc(8);
		chk(16'(drive.low_side_gate), 16'h0001);
		ss <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(REG_DUTY, 16'(rows[i][0]));
			cyc(2 * PERIOD_CYC);
			count_hs(n);
			chk(16'(n), 16'(rows[i][1]));
		end
		wr_reg(REG_DUTY, 16'h01ff);
		rd_reg(REG_DUTY, v);
		chk(v, 16'h01ff);
		cyc(PERIOD_CYC);
		wait_on(1, n);
		chk(16'(n > 19 * PERIOD_CYC && n < 21 * PERIOD_CYC), 16'h0001);
		wr_reg(REG_DUTY, 16'h00a6);
		th <= 1'b1;
		cyc(5 * PERIOD_CYC);
		chk({12'h000, drive}, 16'h0003);
		rd_reg(REG_STATUS, v);
		chk(v, 16'h0028);
		th <= 1'b0;
		wait_on(0, n);
		chk(16'(n >= RCNT * PERIOD_CYC), 16'h0001);
		sc <= 1'b1;
		cyc(10);
		sc <= 1'b0;
		wait_on(0, n);
		chk(16'(n >= RCNT * PERIOD_CYC - 10 && n <= 5 * PERIOD_CYC), 16'h0001);
		wr_reg(REG_DUTY, 16'h0000);
		uv <= 1'b1;
		cyc(5 * PERIOD_CYC);
		chk({12'h000, drive}, 16'h0003);
		uv <= 1'b0;
		wait_on(0, n);
		chk(16'(n < RCNT * PERIOD_CYC), 16'h0001);
		cyc(10);
		chk(16'(drive.low_side_gate), 16'h0000);
		wr_reg(REG_CTRL, 16'h0000);
		cyc(5);
		chk({12'h000, drive}, 16'h0003);
		wr_reg(REG_CTRL, 16'h0001);
		rd_reg(REG_CTRL, v);
		chk(v, 16'h0001);
		// Reset in mid-run
		nrst <= 1'b0;
		cyc(2);
		chk({12'h000, drive}, 16'h0003);
		nrst <= 1'b1;
		rd_reg(REG_CTRL, v);
		chk(v, 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: common/bpfs_pkg.sv */
package bpfs_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned SWITCH_HZ       = 300_000;
	// Switching period in system clocks (rounded down)
	localparam int unsigned PERIOD_CYC      = CLK_HZ / SWITCH_HZ;
	localparam int unsigned HALF_PERIOD_CYC = PERIOD_CYC / 2;
	localparam int unsigned RESTART_MS      = 200;
	// Restart delay counted in switching periods
	localparam int unsigned RESTART_PERIODS = (RESTART_MS * SWITCH_HZ) / 1000;
	localparam int unsigned MAX_ON_PERIODS  = 20;
	localparam int unsigned DUTY_W          = 9;

	// ****************************************
	// Register interface
	// ****************************************
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_DUTY        = 4'h1;
	localparam logic [3:0]  REG_STATUS      = 4'h2;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [15:0] DUTY_RESET      = 16'h0000;

	typedef enum logic [1:0] {
		BPFS_IDLE,
		BPFS_WAIT,
		BPFS_RUN
	} bpfs_state_e;

	typedef struct packed {
		logic undervoltage_lockout;
		logic thermal;
		logic short_circuit;
		logic ss_above_thresh;
		logic switch_node_high;
	} bpfs_flags_s;

	typedef struct packed {
		logic high_side_gate;
		logic low_side_gate;
		logic ss_pulldown;
		logic comp_pulldown;
	} bpfs_drive_s;

endpackage

/* File: verilog/bpfs_core.sv */
// Operation
// RULE1: Any undervoltage, thermal or short-circuit fault forces idle with soft-start and error-amp pulled low and both gates off.
// RULE2: After an undervoltage fault the block stays idle until that fault clears, with no timer.
// RULE3: A thermal or short-circuit fault starts a restart timer of nominally 200 ms.
// RULE4: After a short-circuit fault a restart is tried as soon as the timer expires.
// RULE5: A thermal fault keeps restarting the timer while present, so restart needs the fault gone and a full period.
// RULE6: At start-up the low-side gate stays off until the high-side gate has tried to turn on or soft-start exceeds 1.7 V.
// RULE7: After 20 whole periods with the high-side gate on, the PWM latch is reset mid way through the 21st period.
// RULE8: Gate outputs and the switch node are watched so both switches are never on together.
// RULE9: Duty cycle spans fully off through fully on.
// RULE10: The switching period is fixed at 300 kHz and paces the ramp and PWM logic.
// RULE11: Trailing-edge PWM: high side on at period start, off when the ramp crosses the error-amp level; here the ramp is compared with duty_reg.
// RULE12: The high-side gate is held low while the low-side gate is high or any fault is active.
// RULE13: The restart timer counts oscillator periods and fault inputs are synchronised comparator flags.
// RULE14: A restart releases the pull-downs and re-arms the low-side start-up interlock.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module bpfs_core
#(
	parameter int unsigned RESTART_CNT = bpfs_pkg::RESTART_PERIODS
)
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// Comparator flags from the analog side
	input  wire bpfs_pkg::bpfs_flags_s flags,
	// Register port
	input  wire logic [3:0]            addr,
	input  wire logic [15:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output var  logic [15:0]           rdata,
	// Drivers
	output var  bpfs_pkg::bpfs_drive_s drive
);
	import bpfs_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	bpfs_flags_s sync_flags;

	// Fault inputs
	// RULE13: synchronised flags
	bpfs_sync #(.W($bits(bpfs_flags_s))) u_sync
	(
		.clk  (clk),
		.nrst (nrst),
		.d    (flags),
		.q    (sync_flags)
	);

	logic any_fault;
	assign any_fault = sync_flags.undervoltage_lockout | sync_flags.thermal
	                 | sync_flags.short_circuit;

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] ctrl_reg;
	logic [15:0] duty_reg;
	logic        enable;
	assign enable = ctrl_reg[0];

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctrl_reg <= CTRL_RESET;
			duty_reg <= DUTY_RESET;
		end
		else if (wr)
		begin
			if (addr == REG_CTRL)
				ctrl_reg <= wdata;
			if (addr == REG_DUTY)
				duty_reg <= wdata;
		end
	end

	// ****************************************
	// Oscillator and ramp
	// ****************************************
	logic [DUTY_W-1:0] phase_reg;
	logic              period_start;
	logic              half_point;
	assign period_start = (phase_reg == '0);
	assign half_point   = (phase_reg == DUTY_W'(HALF_PERIOD_CYC));

	// RULE10: fixed 300 kHz period
	always_ff @(posedge clk)
	begin
		if (!nrst)
			phase_reg <= '0;
		else if (phase_reg == DUTY_W'(PERIOD_CYC - 1))
			phase_reg <= '0;
		else
			phase_reg <= phase_reg + 1'b1;
	end

	// ****************************************
	// Fault sequencer
	// ****************************************
	bpfs_state_e state_reg;
	logic [15:0] timer_reg;
	logic        timer_done;
	logic        interlock_reg;
	assign timer_done = (timer_reg == 16'(RESTART_CNT - 1));

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_reg <= BPFS_IDLE;
			timer_reg <= '0;
		end
		else
		begin
			case (state_reg)
				BPFS_RUN:
				begin
					timer_reg <= '0;
					// RULE1: any fault idles
					if (any_fault || !enable)
						state_reg <= (sync_flags.thermal || sync_flags.short_circuit)
						           ? BPFS_WAIT : BPFS_IDLE;
				end
				BPFS_WAIT:
				begin
					// RULE5: thermal recycles timer
					if (sync_flags.thermal)
						timer_reg <= '0;
					// RULE3: restart timer in periods
					else if (period_start && !timer_done)
						timer_reg <= timer_reg + 1'b1;
					// RULE4: restart on expiry
					else if (period_start && timer_done)
						state_reg <= BPFS_IDLE;
				end
				BPFS_IDLE:
				begin
					timer_reg <= '0;
					// RULE2: wait for lockout clear
					// RULE14: restart releases pull-downs
					if (sync_flags.thermal || sync_flags.short_circuit)
						state_reg <= BPFS_WAIT;
					else if (!any_fault && enable && period_start)
						state_reg <= BPFS_RUN;
				end
				default:
					state_reg <= BPFS_IDLE;
			endcase
		end
	end

	// ****************************************
	// PWM latch and gate drive
	// ****************************************
	logic              pwm_reg;
	logic [4:0]        on_periods_reg;
	logic              running;
	logic              want_high;
	logic              want_low;
	assign running = (state_reg == BPFS_RUN) && !any_fault;

	// RULE7: on-time watchdog count
	always_ff @(posedge clk)
	begin
		if (!nrst || !running || !pwm_reg)
			on_periods_reg <= '0;
		else if (period_start && on_periods_reg != 5'(MAX_ON_PERIODS))
			on_periods_reg <= on_periods_reg + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst || !running)
			pwm_reg <= 1'b0;
		// RULE11: set at period start
		else if (period_start)
			pwm_reg <= (duty_reg[DUTY_W-1:0] != '0);
		// RULE9: ramp crosses duty level
		else if (phase_reg >= duty_reg[DUTY_W-1:0])
			pwm_reg <= 1'b0;
		// RULE7: forced reset mid period
		else if (half_point && on_periods_reg == 5'(MAX_ON_PERIODS))
			pwm_reg <= 1'b0;
	end

	// RULE6: low-side interlock
	always_ff @(posedge clk)
	begin
		if (!nrst || !running)
			interlock_reg <= 1'b1;
		else if (drive.high_side_gate || sync_flags.ss_above_thresh)
			interlock_reg <= 1'b0;
	end

	// RULE8: never both on
	// RULE12: high side blocked
	assign want_high = pwm_reg && running && !drive.low_side_gate;
	// Low side lets go at the period start edge, so the high side still rises one
	// clock later and keeps its full on-time
	assign want_low  = !pwm_reg && running && !interlock_reg && !period_start
	                && !drive.high_side_gate && !sync_flags.switch_node_high;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			drive <= '{high_side_gate: 1'b0, low_side_gate: 1'b0,
			           ss_pulldown: 1'b1, comp_pulldown: 1'b1};
		else
		begin
			drive.high_side_gate <= want_high && !any_fault;
			drive.low_side_gate  <= want_low && !any_fault;
			// RULE1: pull-downs while idle
			drive.ss_pulldown    <= !running;
			drive.comp_pulldown  <= !running;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!nrst || !rd)
			rdata <= '0;
		else
			case (addr)
				REG_CTRL:   rdata <= ctrl_reg;
				REG_DUTY:   rdata <= duty_reg;
				REG_STATUS: rdata <= {9'h000, 2'(state_reg), sync_flags};
				default:    rdata <= '0;
			endcase
	end
endmodule
`default_nettype wire

/* File: verilog/bpfs_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module bpfs_sync
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire
